// >>> src/tds_mem.sv
// Purpose: byte-wide device memory, two ports
// Assumes: port a is the scheduler, port b the bus; port b write wins on clash
// Notes: 64 KiB byte array
`timescale 1ns/1ps
`default_nettype none
module tds_mem #(
  parameter int AW = 16
) (
  input wire logic clk_i,
  tds_mem_if.slave pa,
  tds_mem_if.slave pb
);
  logic [7:0] mem [0:(1<<AW)-1];
  logic [7:0] ra_r;
  logic [7:0] rb_r;
  // two ports, scheduler write first so the bus write lands last
  always_ff @(posedge clk_i) begin
    if (pa.we) mem[pa.addr[AW-1:0]] <= pa.wdata;
    if (pb.we) mem[pb.addr[AW-1:0]] <= pb.wdata;
    ra_r <= mem[pa.addr[AW-1:0]];
    rb_r <= mem[pb.addr[AW-1:0]];
  end
  assign pa.rdata = ra_r;
  assign pb.rdata = rb_r;
endmodule
`default_nettype wire

// >>> src/tds_mem_if.sv
// Purpose: byte memory port between scheduler and table memory
// Assumes: one-cycle registered read
// Notes: two ports, scheduler and bus
`timescale 1ns/1ps
`default_nettype none
interface tds_mem_if;
  logic we;
  logic [15:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport master (output we, output addr, output wdata, input rdata);
  modport slave (input we, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// >>> src/tds_pkg.sv
// Purpose: shared constants for the transmit descriptor scheduler
// Assumes: 40 MHz clock, byte-wide device memory behind a simple port
// Notes: register offsets are word byte addresses on the wishbone slave
package tds_pkg;
  localparam int CLK_HZ = 40000000;
  localparam int TICK_MS = 10;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam logic [15:0] TX0_TABLE_BASE = 16'h4000;
  localparam logic [15:0] TABLE_STRIDE = 16'h0800;
  localparam logic [15:0] HOST_FAST_LO = 16'h8000;
  localparam logic [15:0] HOST_FAST_HI = 16'h800F;
  localparam logic [7:0] OP_HOST_READ = 8'h80;
  localparam logic [7:0] OP_HOST_WRITE = 8'h84;
  localparam logic [7:0] ACT_IMMEDIATE = 8'h40;
  localparam logic [7:0] ACT_END_OF_SEQ = 8'h00;
  localparam logic [7:0] ACT_CH0_B2 = 8'hA1;
  localparam logic [7:0] ACT_CH0_B4 = 8'hA3;
  localparam logic [7:0] ACT_CH1_B2 = 8'hA5;
  localparam logic [7:0] ACT_CH1_B4 = 8'hA7;
  localparam logic [15:0] RX_CH_BASE0 = 16'h0000;
  localparam logic [15:0] RX_CH_BASE1 = 16'h0400;
  localparam int MAX_DESC = 256;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_RATE = 8'h08;
  localparam logic [7:0] ADDR_MAP = 8'h0C;
  localparam logic [7:0] ADDR_DATA = 8'h10;
  localparam logic [7:0] ADDR_RXCTL = 8'h14;
  localparam logic [7:0] ADDR_WORD = 8'h18;
  localparam logic [7:0] ADDR_RXMSG = 8'h1C;
  localparam logic [2:0] MODE_AUTO_A = 3'h1;
  localparam logic [2:0] MODE_AUTO_B = 3'h3;
  typedef enum logic [2:0] {
    TDS_IDLE = 3'b000, TDS_WAIT = 3'b001, TDS_ACT = 3'b011,
    TDS_VAL = 3'b010, TDS_DATA = 3'b110, TDS_CLR = 3'b111,
    TDS_EMIT = 3'b101
  } tds_state_e;
endpackage

// >>> src/tds_rx_store.sv
// Purpose: write a received message block with its status byte
// Assumes: one message per strobe, block = status + 4 bytes at base+label*8
// Notes: takes memory over from the scheduler for five cycles
`timescale 1ns/1ps
`default_nettype none
module tds_rx_store (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic go_i,
  input wire logic chan_i,
  input wire logic [31:0] msg_i,
  output logic busy_o,
  output logic we_o,
  output logic [15:0] addr_o,
  output logic [7:0] data_o
);
  logic [2:0] cnt_r, cnt_nxt;
  logic [31:0] msg_r, msg_nxt;
  logic [15:0] base_r, base_nxt;
  logic [1:0] bsel;
  // step through status byte then four word bytes
  always_comb begin
    cnt_nxt = cnt_r;
    msg_nxt = msg_r;
    base_nxt = base_r;
    if (cnt_r == 3'h0 && go_i) begin
      cnt_nxt = 3'h5;
      msg_nxt = msg_i;
      base_nxt = (chan_i ? 16'h0400 : 16'h0000) + {5'h00, msg_i[7:0], 3'h0};
    end else if (cnt_r != 3'h0) begin
      cnt_nxt = cnt_r - 3'h1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= 3'h0;
      msg_r <= 32'h0000_0000;
      base_r <= 16'h0000;
    end else begin
      cnt_r <= cnt_nxt;
      msg_r <= msg_nxt;
      base_r <= base_nxt;
    end
  end
  assign busy_o = (cnt_r != 3'h0);
  assign we_o = busy_o;
  assign addr_o = base_r + {13'h0000, 3'h5 - cnt_r};
  // status byte all ones on arrival
  // word bytes 2..4 at +1..+3, label byte last at +4
  assign bsel = 2'(3'h5 - cnt_r);
  assign data_o = (cnt_r == 3'h5) ? 8'hFF : msg_r[8*bsel +: 8];
endmodule
`default_nettype wire

// >>> src/tds_top.sv
// Purpose: transmit descriptor scheduler with wishbone register access
// Assumes: synchronous inputs, classic wishbone, one transmitter table walked
// Notes: ack comes one cycle after request, read data valid with ack
// Behaviour
// - run rising starts sequence 0, paced by free running 10 ms tick
// - finished sequence repeats every rate ticks, next tick at rate 1; minimum period 10 ms
// - received message writes a status byte with every bit set
// - status byte holds four per-transmitter new-data flags
// - fetch from a block clears only this transmitter's flag
// - immediate action sends its value byte unchanged
// - indexed conditional action sends selected byte of stored message
// - tx0 table at 0x4000, four pairs per descriptor, codes 40, A1-A3, A5-A7
// - action byte 0x00 in the first pair of a descriptor ends the sequence
// - all descriptors of a table are walked in turn each pass; one whose flag test finds the flag clear is not sent
// - mode 1 or 3 at reset starts autonomous load from eeprom
// - up to 256 descriptors per transmitter table
// - run low halts the scheduler
// - rate zero sends once per run rising edge
`timescale 1ns/1ps
`default_nettype none
module tds_top
  import tds_pkg::*;
#(
  parameter int TICK = TICK_CYCLES,
  parameter logic [1:0] TX_SEL = 2'h0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic [2:0] mode_i,
  input wire logic rx_valid_i,
  input wire logic rx_chan_i,
  input wire logic [31:0] rx_msg_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic tx_valid_o,
  output logic [31:0] tx_word_o,
  output logic auto_load_o
);
  tds_mem_if ma();
  tds_mem_if mb();
  logic rs_busy, rs_we;
  logic [15:0] rs_addr;
  logic [7:0] rs_data;
  tds_mem u_mem (.clk_i(clk_i), .pa(ma), .pb(mb));
  tds_rx_store u_rx (.clk_i(clk_i), .rst_i(rst_i), .go_i(rx_valid_i), .chan_i(rx_chan_i),
    .msg_i(rx_msg_i), .busy_o(rs_busy), .we_o(rs_we), .addr_o(rs_addr), .data_o(rs_data));

  // pointer for bytes in a descriptor -> address of source byte in rx block
  function automatic logic [15:0] src_addr(input logic [7:0] act, input logic [7:0] val);
    logic [15:0] b;
    b = (act >= ACT_CH1_B2) ? RX_CH_BASE1 : RX_CH_BASE0;
    src_addr = b + {5'h00, val, 3'h0} + {14'h0000, act[1:0]};
  endfunction
  function automatic logic is_idc(input logic [7:0] a);
    is_idc = (a >= ACT_CH0_B2 && a <= ACT_CH0_B4) || (a >= ACT_CH1_B2 && a <= ACT_CH1_B4);
  endfunction

  // tick timer, free running
  logic [31:0] tick_cnt_r, tick_cnt_nxt;
  logic tick;
  assign tick = (tick_cnt_r == 32'(TICK - 1));
  always_comb tick_cnt_nxt = tick ? 32'h0 : tick_cnt_r + 32'h1;
  always_ff @(posedge clk_i) begin
    if (rst_i) tick_cnt_r <= 32'h0;
    else tick_cnt_r <= tick_cnt_nxt;
  end

  // registers
  logic [7:0] rate_r, rate_nxt;
  logic [15:0] map_r, map_nxt;
  logic [7:0] rxctl_r, rxctl_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic rd_pend_r, rd_pend_nxt;
  logic run_d_r, auto_r, auto_nxt, boot_r;
  logic [7:0] rate_cnt_r, rate_cnt_nxt;

  // scheduler state
  tds_state_e st_r, st_nxt;
  logic [15:0] ptr_r, ptr_nxt;
  logic [1:0] slot_r, slot_nxt;
  logic [7:0] act_r, act_nxt;
  logic [31:0] word_r, word_nxt;
  logic keep_r, keep_nxt;
  logic [8:0] ndesc_r, ndesc_nxt;
  logic txv_r, txv_nxt;
  logic [15:0] flag_addr_r, flag_addr_nxt;
  logic [7:0] flag_r, flag_nxt;
  logic seen_r, seen_nxt;
  logic [15:0] seen_addr_r, seen_addr_nxt;
  logic [31:0] out_r, out_nxt;
  logic busy_d_r, stall;
  logic [15:0] sch_addr_r;
  logic run_rise;
  logic bus_mem;
  logic sch_we;
  logic [15:0] sch_addr;
  logic [7:0] sch_wdata;
  logic [15:0] base;

  assign run_rise = run_i && !run_d_r;
  assign base = TX0_TABLE_BASE + {TX_SEL, 14'h0000} / 16'h0008 * 16'h0002;
  assign bus_mem = cyc_i && stb_i && adr_i == ADDR_DATA && !ack_r;
  // port a lent to the receive store, plus one cycle to replay the lost read
  assign stall = rs_busy || busy_d_r;

  // scheduler walk
  always_comb begin
    st_nxt = st_r;
    ptr_nxt = ptr_r;
    slot_nxt = slot_r;
    act_nxt = act_r;
    word_nxt = word_r;
    keep_nxt = keep_r;
    ndesc_nxt = ndesc_r;
    txv_nxt = 1'b0;
    flag_addr_nxt = flag_addr_r;
    flag_nxt = flag_r;
    seen_nxt = seen_r;
    seen_addr_nxt = seen_addr_r;
    rate_cnt_nxt = rate_cnt_r;
    sch_we = 1'b0;
    sch_addr = ptr_r;
    sch_wdata = 8'h00;
    case (st_r)
      TDS_IDLE: begin
        if (run_rise) begin
          st_nxt = TDS_WAIT;
          rate_cnt_nxt = 8'h00;
        end
      end
      TDS_WAIT: begin
        if (tick) begin
          if (rate_cnt_r == 8'h00 || rate_cnt_r >= rate_r) begin
            st_nxt = TDS_ACT;
            ptr_nxt = base;
            slot_nxt = 2'h0;
            keep_nxt = 1'b1;
            ndesc_nxt = 9'h000;
            seen_nxt = 1'b0;
            rate_cnt_nxt = 8'h01;
          end else begin
            rate_cnt_nxt = rate_cnt_r + 8'h01;
          end
        end
      end
      TDS_ACT: begin
        st_nxt = TDS_VAL; // action byte address already on the port
      end
      TDS_VAL: begin
        act_nxt = ma.rdata;
        sch_addr = ptr_r + 16'h0001;
        if (slot_r == 2'h0 && (ma.rdata == ACT_END_OF_SEQ || ndesc_r == 9'(MAX_DESC))) begin
          st_nxt = (rate_r == 8'h00) ? TDS_IDLE : TDS_WAIT;
        end else begin
          st_nxt = TDS_DATA;
        end
      end
      TDS_DATA: begin
        if (act_r == ACT_IMMEDIATE) begin
          word_nxt[8*slot_r +: 8] = ma.rdata;
          st_nxt = TDS_EMIT;
        end else if (is_idc(act_r)) begin
          sch_addr = src_addr(act_r, ma.rdata);
          flag_addr_nxt = src_addr(act_r, ma.rdata) & 16'hFFF8;
          st_nxt = TDS_CLR;
        end else begin
          st_nxt = TDS_EMIT;
        end
      end
      TDS_CLR: begin
        // data byte arrives now; fetch status for flag test
        word_nxt[8*slot_r +: 8] = ma.rdata;
        sch_addr = flag_addr_r;
        st_nxt = TDS_EMIT;
        act_nxt = 8'hFF;
      end
      TDS_EMIT: begin
        // one flag test per block until another block is tested in the descriptor, so later bytes are not skipped
        if (act_r == 8'hFF && !(seen_r && seen_addr_r == flag_addr_r)) begin
          flag_nxt = ma.rdata;
          if (!ma.rdata[TX_SEL]) keep_nxt = 1'b0;
          sch_we = 1'b1;
          sch_addr = flag_addr_r;
          sch_wdata = ma.rdata & ~(8'h01 << TX_SEL);
          seen_nxt = 1'b1;
          seen_addr_nxt = flag_addr_r;
        end
        ptr_nxt = ptr_r + 16'h0002;
        slot_nxt = slot_r + 2'h1;
        st_nxt = TDS_ACT;
        if (slot_r == 2'h3) begin
          txv_nxt = keep_nxt;
          keep_nxt = 1'b1;
          seen_nxt = 1'b0;
          ndesc_nxt = ndesc_r + 9'h001;
        end
      end
      default: st_nxt = TDS_IDLE;
    endcase
    // freeze the walk while the store owns memory, then reissue the last read
    if (stall && st_r != TDS_IDLE && st_r != TDS_WAIT) begin
      st_nxt = st_r;
      ptr_nxt = ptr_r;
      slot_nxt = slot_r;
      act_nxt = act_r;
      word_nxt = word_r;
      keep_nxt = keep_r;
      ndesc_nxt = ndesc_r;
      txv_nxt = 1'b0;
      flag_addr_nxt = flag_addr_r;
      flag_nxt = flag_r;
      seen_nxt = seen_r;
      seen_addr_nxt = seen_addr_r;
      sch_we = 1'b0;
      sch_addr = sch_addr_r;
    end
    // output word only moves when a word is sent
    out_nxt = txv_nxt ? word_r : out_r;
    if (!run_i) st_nxt = TDS_IDLE;
  end

  // memory port muxing: receive store, then scheduler
  assign ma.we = rs_busy ? rs_we : sch_we;
  assign ma.addr = rs_busy ? rs_addr : sch_addr;
  assign ma.wdata = rs_busy ? rs_data : sch_wdata;
  assign mb.we = bus_mem && we_i && sel_i[0] && map_r != 16'h0000;
  assign mb.addr = map_r;
  assign mb.wdata = dat_i[7:0];

  // bus side register next values
  always_comb begin
    rate_nxt = rate_r;
    map_nxt = map_r;
    rxctl_nxt = rxctl_r;
    ack_nxt = cyc_i && stb_i && !ack_r;
    dat_nxt = dat_r;
    rd_pend_nxt = 1'b0;
    auto_nxt = auto_r;
    if (boot_r && (mode_i == MODE_AUTO_A || mode_i == MODE_AUTO_B)) auto_nxt = 1'b1;
    if (cyc_i && stb_i && !ack_r) begin
      if (we_i) begin
        case (adr_i)
          ADDR_RATE: if (sel_i[0]) rate_nxt = dat_i[7:0];
          ADDR_MAP: map_nxt = {sel_i[1] ? dat_i[15:8] : map_r[15:8], sel_i[0] ? dat_i[7:0] : map_r[7:0]};
          ADDR_RXCTL: if (sel_i[0] && !run_i) rxctl_nxt = dat_i[7:0];
          default: ;
        endcase
      end else begin
        case (adr_i)
          ADDR_CTRL: dat_nxt = {28'h0, 1'b0, auto_r, 1'b0, run_i};
          ADDR_STATUS: dat_nxt = {21'h0, st_r, ndesc_r[7:0]};
          ADDR_RATE: dat_nxt = {24'h0, rate_r};
          ADDR_MAP: dat_nxt = {16'h0, map_r};
          ADDR_RXCTL: dat_nxt = {24'h0, rxctl_r};
          ADDR_DATA: dat_nxt = {24'h0, mb.rdata};
          ADDR_WORD: dat_nxt = out_r;
          ADDR_RXMSG: dat_nxt = {24'h0, flag_r};
          default: dat_nxt = 32'h0;
        endcase
      end
    end
    if (rd_pend_r) dat_nxt = {24'h0, mb.rdata};
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= TDS_IDLE;
      ptr_r <= 16'h0000;
      slot_r <= 2'h0;
      act_r <= 8'h00;
      word_r <= 32'h0;
      keep_r <= 1'b0;
      ndesc_r <= 9'h000;
      txv_r <= 1'b0;
      flag_addr_r <= 16'h0000;
      flag_r <= 8'h00;
      seen_r <= 1'b0;
      seen_addr_r <= 16'h0000;
      out_r <= 32'h0;
      busy_d_r <= 1'b0;
      sch_addr_r <= 16'h0000;
      rate_cnt_r <= 8'h00;
      rate_r <= 8'h01;
      map_r <= 16'h0000;
      rxctl_r <= 8'h00;
      ack_r <= 1'b0;
      dat_r <= 32'h0;
      rd_pend_r <= 1'b0;
      run_d_r <= 1'b0;
      auto_r <= 1'b0;
      boot_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      ptr_r <= ptr_nxt;
      slot_r <= slot_nxt;
      act_r <= act_nxt;
      word_r <= word_nxt;
      keep_r <= keep_nxt;
      ndesc_r <= ndesc_nxt;
      txv_r <= txv_nxt;
      flag_addr_r <= flag_addr_nxt;
      flag_r <= flag_nxt;
      seen_r <= seen_nxt;
      seen_addr_r <= seen_addr_nxt;
      out_r <= out_nxt;
      busy_d_r <= rs_busy;
      sch_addr_r <= sch_addr;
      rate_cnt_r <= rate_cnt_nxt;
      rate_r <= rate_nxt;
      map_r <= map_nxt;
      rxctl_r <= rxctl_nxt;
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
      rd_pend_r <= bus_mem && !we_i;
      run_d_r <= run_i;
      auto_r <= auto_nxt;
      boot_r <= 1'b0;
    end
  end

  assign ack_o = ack_r;
  assign dat_o = dat_r;
  assign tx_valid_o = txv_r;
  assign tx_word_o = out_r;
  assign auto_load_o = auto_r;
endmodule
`default_nettype wire

// >>> verification/tds_rx_src.sv
// Purpose: receive side model feeding messages to the store
// Assumes: one message per call, store busy five cycles
// Notes: idle lines carry the inverse of the last message
`timescale 1ns/1ps
`default_nettype none
module tds_rx_src (
  input wire logic clk_i,
  output logic valid_o,
  output logic chan_o,
  output logic [31:0] msg_o
);
  // idle values at time zero
  initial begin
    valid_o = 1'b0;
    chan_o = 1'b0;
    msg_o = 32'h0;
  end
  // one-cycle strobe, then wait out the store
  task automatic send(input logic ch, input logic [31:0] m);
    @(posedge clk_i);
    valid_o <= 1'b1;
    chan_o <= ch;
    msg_o <= m;
    @(posedge clk_i);
    valid_o <= 1'b0;
    chan_o <= ~ch;
    msg_o <= ~m; // stale data unusable
    repeat (6) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// >>> verification/tds_top_sva.sv
// Purpose: port checks for the descriptor scheduler
// Assumes: one clock, sync reset, strap held steady outside reset
// Notes: bound to tds_top from the bench
`timescale 1ns/1ps
`default_nettype none
module tds_top_sva #(
  parameter int TICK = 40
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic [2:0] mode_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic tx_valid_o,
  input wire logic [31:0] tx_word_o,
  input wire logic auto_load_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // bus request and its one-cycle answer
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_ans;
    ack_o ##1 !ack_o;
  endsequence
  a_ack_after_req: assert property (s_req |=> s_ans) else $error("ack missing after request");
  a_ack_needs_req: assert property (!(cyc_i && stb_i) |=> !ack_o) else $error("ack without request");
  a_unmapped_zero: assert property (ack_o && !we_i && adr_i == 8'h40 |-> dat_o == 32'h0) else $error("unmapped read");
  a_dat_holds: assert property (!ack_o && $past(!ack_o) && $past(!ack_o, 2) |-> $stable(dat_o))
    else $error("read data moved");
  // transmit word output and strap load
  a_tx_pulse: assert property (tx_valid_o |=> !tx_valid_o [*2]) else $error("word pulse too long");
  a_word_held: assert property (!tx_valid_o |-> $stable(tx_word_o)) else $error("word moved while idle");
  a_halt_quiet: assert property (!run_i [*8] |=> !tx_valid_o) else $error("word sent while halted");
  a_strap_load: assert property (!rst_i [*4] |-> auto_load_o == (mode_i == 3'h1 || mode_i == 3'h3))
    else $error("auto load wrong");
endmodule
`default_nettype wire

// >>> verification/tds_top_test.sv
// Purpose: self-checking bench for the descriptor scheduler
// Assumes: short tick of 40 cycles, classic wishbone host
// Notes: two-descriptor concentrator table
`timescale 1ns/1ps
`default_nettype none
module tds_top_test;
  import tds_pkg::*;
  localparam int TK = 40;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic run_i = 1'b0;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [2:0] mode_i = 3'h7;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o, tx_word_o, rx_msg, rd;
  logic ack_o, tx_valid_o, auto_load_o, rx_valid, rx_chan;
  int failures = 0;
  int tests_run = 0;
  logic [31:0] q[$];
  logic [7:0] tbl[17] = '{8'h40, 8'h51, 8'hA1, 8'h00, 8'hA2, 8'h00, 8'hA3, 8'h00,
    8'h40, 8'h52, 8'hA5, 8'h00, 8'hA6, 8'h00, 8'hA7, 8'h00, 8'h00};
  tds_top #(.TICK(TK)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .run_i(run_i), .mode_i(mode_i),
    .rx_valid_i(rx_valid), .rx_chan_i(rx_chan), .rx_msg_i(rx_msg), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .tx_valid_o(tx_valid_o), .tx_word_o(tx_word_o), .auto_load_o(auto_load_o));
  tds_rx_src src_u (.clk_i(clk_i), .valid_o(rx_valid), .chan_o(rx_chan), .msg_o(rx_msg));
  // clock
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  // collect sent words
  always @(posedge clk_i) begin
    if (tx_valid_o === 1'b1) q.push_back(tx_word_o);
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // one classic cycle, held until ack is seen
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hF;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    rd = dat_o;
    if (n >= 50) failures++;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask
  task automatic mem_wr(input logic [15:0] a, input logic [7:0] d);
    wb(1'b1, ADDR_MAP, {16'h0, a});
    wb(1'b1, ADDR_DATA, {24'h0, d});
  endtask
  // data stands with the ack; the second read repeats the first
  task automatic mem_rd(input logic [15:0] a);
    wb(1'b1, ADDR_MAP, {16'h0, a});
    wb(1'b0, ADDR_DATA, 32'h0);
    wb(1'b0, ADDR_DATA, 32'h0);
  endtask
  task automatic ticks(input int n);
    repeat (n * TK) @(posedge clk_i);
  endtask
  // main sequence
  initial begin
    for (int m = 7; m >= 0; m--) begin
      mode_i <= 3'(m);
      rst_i <= 1'b1;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      check({31'h0, auto_load_o}, {31'h0, m == 1 || m == 3});
    end
    wb(1'b0, 8'h40, 32'h0);
    check(rd, 32'h0);
    wb(1'b0, ADDR_RATE, 32'h0);
    check(rd, 32'h1);
    for (int i = 0; i < 17; i++) mem_wr(TX0_TABLE_BASE + 16'(i), tbl[i]);
    mem_wr(RX_CH_BASE0, 8'h00);
    mem_wr(RX_CH_BASE1, 8'h00);
    mem_rd(TX0_TABLE_BASE + 16'h9);
    check(rd, 32'h52);
    $display("test setup done");
    run_i <= 1'b1;
    ticks(3);
    check(32'(q.size()), 32'h0);
    src_u.send(1'b0, 32'h56340200);
    ticks(3);
    check(32'(q.size()), 32'h1);
    check(q[0], 32'h56340251);
    mem_rd(RX_CH_BASE0);
    check(rd, 32'hFE);
    q.delete();
    ticks(3);
    check(32'(q.size()), 32'h0);
    $display("test repeater done");
    wb(1'b1, ADDR_RXCTL, 32'h5A);
    wb(1'b0, ADDR_RXCTL, 32'h0);
    check(rd, 32'h0);
    src_u.send(1'b0, 32'h56340200);
    src_u.send(1'b1, 32'h56340300);
    ticks(3);
    check(32'(q.size()), 32'h2);
    check(q[0], 32'h56340251);
    check(q[1], 32'h56340352);
    $display("test concentrator done");
    run_i <= 1'b0;
    q.delete();
    src_u.send(1'b0, 32'h56340200);
    ticks(3);
    check(32'(q.size()), 32'h0);
    wb(1'b1, ADDR_RXCTL, 32'h3C);
    wb(1'b0, ADDR_RXCTL, 32'h0);
    check(rd, 32'h3C);
    wb(1'b1, ADDR_RATE, 32'h0);
    run_i <= 1'b1;
    ticks(4);
    check(32'(q.size()), 32'h1);
    src_u.send(1'b0, 32'h56340200);
    ticks(3);
    check(32'(q.size()), 32'h1);
    $display("test halt and one shot done");
    end_sim();
  end
  // watchdog
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    end_sim();
  end
endmodule
bind tds_top tds_top_sva #(.TICK(TICK)) sva_u (.clk_i(clk_i), .rst_i(rst_i), .run_i(run_i),
  .mode_i(mode_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o),
  .ack_o(ack_o), .tx_valid_o(tx_valid_o), .tx_word_o(tx_word_o), .auto_load_o(auto_load_o));
`default_nettype wire
